//--- verilog/ptu_timer.v
// Behaviour
// - After reset every counter free-runs; no compare clear source active.
// - Setting a channel run bit makes its counter count up per tick.
// - Counter wrapping from ffff to zero sets that channel's overflow flag.
// - Overflow flag with its enable set raises the channel interrupt request.
// - After overflow the counter keeps counting upward from zero.
// - Clear source selecting a general register makes the count periodic.
// - Count equal to general register sets match flag; clears counter if it is the clear source.
// - Match or capture flag with its enable set raises interrupt request.
// - Compare match drives pin low, high or toggled as configured.
// - Commanded level equal to present level leaves the pin unchanged.
// - Capture mode copies counter into general register on selected edge.
// - Capture edge selectable as rising, falling or both.
// - Channels 0,1,3,4 may capture on neighbour clock or compare match.
// - Channels 0,3 never capture on neighbour clock when it is undivided.
// - Writing a synchronous counter loads all synchronous counters together.
// - Sync-clear counters clear when another synchronous channel clears.
// - All six channels may join synchronous operation.
// - Buffer mode only on channels 0,3: C buffers A, D buffers B.
// - Buffered compare copies buffer into its general register on match.
// - Buffered capture loads counter and moves old value into buffer.
// - Buffered match changes pin and transfers buffer together, every match.
// - Clearing run bit halts counter, pin keeps its last level.
`timescale 1ns/1ps
`default_nettype none
`include "ptu_timer_map.vh"

module ptu_timer #(
  parameter NCH    = 6,
  parameter ADDR_W = 12
) (
  // Clock and reset
  input  wire              CORE_CLK,
  input  wire              SYS_RST,
  // AHB-Lite slave
  input  wire              HSEL,
  input  wire [ADDR_W-1:0] HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output wire [31:0]       HRDATA,
  output wire              HREADYOUT,
  output wire              HRESP,
  // Timer pins
  input  wire [NCH-1:0]    PIN_A_IN,
  input  wire [NCH-1:0]    PIN_B_IN,
  output wire [NCH-1:0]    PIN_A_OUT,
  output wire [NCH-1:0]    PIN_A_OE,
  output wire [NCH-1:0]    PIN_B_OUT,
  output wire [NCH-1:0]    PIN_B_OE,
  // Per-channel interrupt requests
  output wire [NCH-1:0]    IRQ_REQ
);

  //////////////////////////////////////////////////////////////////////////
  // Bus slave

  reg              wr_pend_q;
  reg [ADDR_W-1:0] wr_addr_q;
  reg              rd_pend_q;
  reg [ADDR_W-1:0] rd_addr_q;
  reg              hready_q;
  reg              hresp_q;
  reg [31:0]       hrdata_q;
  reg [NCH-1:0]    run_q;
  reg [NCH-1:0]    sync_q;
  reg [5:0]        pre_q;
  wire [32*NCH-1:0] ch_rd;
  wire [NCH-1:0]   tick;
  wire [NCH-1:0]   div1;
  wire [NCH-1:0]   match_a;
  wire [NCH-1:0]   own_clr;
  wire [NCH-1:0]   cnt_wr;
  wire             accept;
  wire             sync_wr;
  wire             sync_clr;
  wire [2:0]       wr_ch;
  wire [3:0]       wr_word;

  // Size is ignored: only whole-word transfers are in use
  assign accept  = HSEL & HREADY & HTRANS[`PTU_HTRANS_NSEQ];
  assign wr_ch   = wr_addr_q[`PTU_CH_NUM_R];
  assign wr_word = wr_addr_q[`PTU_WORD_R];

  // Writes finish with no wait; reads take one wait so a write in its data
  // phase is already stored when the read word is sampled
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {ADDR_W{1'b0}};
      rd_pend_q <= 1'b0;
      rd_addr_q <= {ADDR_W{1'b0}};
      hready_q  <= 1'b1;
      hresp_q   <= 1'b0;
    end else begin
      wr_pend_q <= accept & HWRITE;
      rd_pend_q <= accept & ~HWRITE;
      hready_q  <= ~(accept & ~HWRITE);
      hresp_q   <= 1'b0;
      if (accept) begin
        wr_addr_q <= HADDR;
        rd_addr_q <= HADDR;
      end
    end
  end

  // Read word from the held address; unmapped reads give zero
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      if (rd_addr_q[`PTU_CH_NUM_R] == 3'h0) begin
        case (rd_addr_q[`PTU_WORD_R])
          `PTU_RUN_OFS:  hrdata_q <= {{(32-NCH){1'b0}}, run_q};
          `PTU_SYNC_OFS: hrdata_q <= {{(32-NCH){1'b0}}, sync_q};
          default:       hrdata_q <= 32'h0000_0000;
        endcase
      end else if (rd_addr_q[`PTU_CH_NUM_R] <= NCH) begin
        hrdata_q <= ch_rd[32*(rd_addr_q[`PTU_CH_NUM_R]-3'h1) +: 32];
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // Run and synchronous select bits
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      run_q  <= {NCH{1'b0}};
      sync_q <= {NCH{1'b0}};
    end else if (wr_pend_q && wr_ch == 3'h0) begin
      if (wr_word == `PTU_RUN_OFS)
        run_q <= HWDATA[NCH-1:0];
      if (wr_word == `PTU_SYNC_OFS)
        sync_q <= HWDATA[NCH-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared prescaler and cross-channel links

  // One divider for all channels keeps synchronous counters in step
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      pre_q <= 6'h00;
    else
      pre_q <= pre_q + 6'h01;
  end

  function psc_tick;
    input [1:0] sel;
    input [5:0] pre;
    begin
      case (sel)
        `PTU_PSC_DIV1:  psc_tick = 1'b1;
        `PTU_PSC_DIV4:  psc_tick = (pre[1:0] == `PTU_PRE_MAX4);
        `PTU_PSC_DIV16: psc_tick = (pre[3:0] == `PTU_PRE_MAX16);
        default:        psc_tick = (pre == `PTU_PRE_MAX64);
      endcase
    end
  endfunction

  // Edge decode shared by both capture inputs
  function edge_hit;
    input [1:0] mode;
    input       now;
    input       was;
    begin
      case (mode)
        `PTU_EDGE_RISE: edge_hit = now & ~was;
        `PTU_EDGE_FALL: edge_hit = ~now & was;
        default:        edge_hit = now ^ was;
      endcase
    end
  endfunction

  // Pin drives only in an output mode, never while capturing
  function oe_of;
    input [3:0] io;
    oe_of = ~io[`PTU_IO_CAP] & (io[`PTU_IO_MODE_R] != `PTU_OUT_NONE);
  endfunction

  assign sync_wr  = |(cnt_wr & sync_q);
  assign sync_clr = |(own_clr & sync_q);

  //////////////////////////////////////////////////////////////////////////
  // Channels

  genvar n;
  generate
    for (n = 0; n < NCH; n = n + 1) begin : g_ch
      localparam HAS_BUF = (n == 0) || (n == 3);
      reg  [6:0]  ctl_q;
      reg  [7:0]  io_q;
      reg  [`PTU_FLG_W-1:0] ien_q;
      reg  [`PTU_FLG_W-1:0] flg_q;
      reg  [15:0] cnt_q;
      reg  [15:0] gra_q;
      reg  [15:0] grb_q;
      reg  [15:0] grc_q;
      reg  [15:0] grd_q;
      reg         pa_q;
      reg         pb_q;
      reg         ina_q;
      reg         inb_q;
      reg         irq_q;
      reg  [1:0]  oe_q;
      reg  [31:0] rd_w;
      wire [3:0]  ioa = io_q[`PTU_IO_A_R];
      wire [3:0]  iob = io_q[`PTU_IO_B_R];
      wire [2:0]  clr = ctl_q[`PTU_CTL_CLR_R];
      wire        sel = wr_pend_q && (wr_ch == n + 1);
      wire        cap_a_md = ioa[`PTU_IO_CAP];
      wire        cap_b_md = iob[`PTU_IO_CAP];
      wire        buf_a = HAS_BUF && ctl_q[`PTU_CTL_BUFA];
      wire        buf_b = HAS_BUF && ctl_q[`PTU_CTL_BUFB];
      wire        cmp_a = ~cap_a_md & tick[n] & (cnt_q == gra_q);
      wire        cmp_b = ~cap_b_md & tick[n] & (cnt_q == grb_q);
      wire        int_ev;
      wire        cap_a;
      wire        cap_b;
      wire        clr_now;
      wire        load;
      wire [`PTU_FLG_W-1:0] set_f;

      assign tick[n]    = run_q[n] & psc_tick(ctl_q[`PTU_CTL_PSC_R], pre_q);
      assign div1[n]    = (ctl_q[`PTU_CTL_PSC_R] == `PTU_PSC_DIV1);
      assign match_a[n] = cmp_a;
      assign cnt_wr[n]  = sel && (wr_word == `PTU_CNT_OFS);

      // Internal capture source: neighbour count clock or compare match
      if (n == 0 || n == 3) begin : g_clk_src
        assign int_ev = tick[n+1] & ~div1[n+1];
      end else if (n == 1 || n == 4) begin : g_cmp_src
        assign int_ev = match_a[n-1];
      end else begin : g_no_src
        assign int_ev = 1'b0;
      end

      // Pin edges or internal source, per configured edge
      assign cap_a = cap_a_md & (ioa[`PTU_IO_INT] ? int_ev :
                     edge_hit(ioa[`PTU_IO_MODE_R], PIN_A_IN[n], ina_q));
      assign cap_b = cap_b_md & (iob[`PTU_IO_INT] ? int_ev :
                     edge_hit(iob[`PTU_IO_MODE_R], PIN_B_IN[n], inb_q));

      // Own clear from match or capture; sync-clear follows a partner
      assign own_clr[n] = (clr == `PTU_CLR_A && (cmp_a || cap_a)) ||
                          (clr == `PTU_CLR_B && (cmp_b || cap_b));
      assign clr_now = own_clr[n] ||
                       (clr == `PTU_CLR_SYNC && sync_q[n] && sync_clr);
      assign load = cnt_wr[n] | (sync_q[n] & sync_wr);

      assign set_f = {tick[n] && !clr_now && cnt_q == `PTU_CNT_MAX,
                      2'b00, cmp_b | cap_b, cmp_a | cap_a};

      // Counter: preset beats clear beats count
      always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST)
          cnt_q <= `PTU_CNT_ZERO;
        else if (load)
          cnt_q <= HWDATA[15:0];
        else if (clr_now)
          cnt_q <= `PTU_CNT_ZERO;
        else if (tick[n])
          cnt_q <= cnt_q + 16'h0001;
      end

      // Setup registers; reset leaves no clear source (free-running)
      always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          ctl_q <= `PTU_CTL_RST;
          io_q  <= `PTU_IO_RST;
          ien_q <= `PTU_FLG_RST;
          oe_q  <= 2'b00;
        end else if (sel) begin
          if (wr_word == `PTU_CTL_OFS)
            ctl_q <= HWDATA[6:0];
          if (wr_word == `PTU_IO_OFS)
            io_q <= HWDATA[7:0];
          if (wr_word == `PTU_IO_OFS)
            oe_q <= {oe_of(HWDATA[`PTU_IO_B_R]), oe_of(HWDATA[`PTU_IO_A_R])};
          if (wr_word == `PTU_IEN_OFS)
            ien_q <= HWDATA[`PTU_FLG_W-1:0];
        end
      end

      // Flags clear by writing one; a new event in that cycle wins
      always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          flg_q <= `PTU_FLG_RST;
          irq_q <= 1'b0;
        end else begin
          if (sel && wr_word == `PTU_FLG_OFS)
            flg_q <= (flg_q & ~HWDATA[`PTU_FLG_W-1:0]) | set_f;
          else
            flg_q <= flg_q | set_f;
          irq_q <= |(flg_q & ien_q);
        end
      end

      // General and buffer registers; hardware events beat bus writes
      always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          gra_q <= `PTU_CNT_MAX;
          grb_q <= `PTU_CNT_MAX;
          grc_q <= `PTU_CNT_MAX;
          grd_q <= `PTU_CNT_MAX;
        end else begin
          if (cap_a)
            gra_q <= cnt_q;
          else if (cmp_a && buf_a)
            gra_q <= grc_q;
          else if (sel && wr_word == `PTU_GRA_OFS)
            gra_q <= HWDATA[15:0];
          if (cap_b)
            grb_q <= cnt_q;
          else if (cmp_b && buf_b)
            grb_q <= grd_q;
          else if (sel && wr_word == `PTU_GRB_OFS)
            grb_q <= HWDATA[15:0];
          if (cap_a && buf_a)
            grc_q <= gra_q;
          else if (HAS_BUF && sel && wr_word == `PTU_GRC_OFS)
            grc_q <= HWDATA[15:0];
          if (cap_b && buf_b)
            grd_q <= grb_q;
          else if (HAS_BUF && sel && wr_word == `PTU_GRD_OFS)
            grd_q <= HWDATA[15:0];
        end
      end

      // Pin levels move only on a match, so stopping holds them
      always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          pa_q  <= 1'b0;
          pb_q  <= 1'b0;
          ina_q <= 1'b0;
          inb_q <= 1'b0;
        end else begin
          ina_q <= PIN_A_IN[n];
          inb_q <= PIN_B_IN[n];
          if (cmp_a) begin
            case (ioa[`PTU_IO_MODE_R])
              `PTU_OUT_LOW:    pa_q <= 1'b0;
              `PTU_OUT_HIGH:   pa_q <= 1'b1;
              `PTU_OUT_TOGGLE: pa_q <= ~pa_q;
              default:         pa_q <= pa_q;
            endcase
          end
          if (cmp_b) begin
            case (iob[`PTU_IO_MODE_R])
              `PTU_OUT_LOW:    pb_q <= 1'b0;
              `PTU_OUT_HIGH:   pb_q <= 1'b1;
              `PTU_OUT_TOGGLE: pb_q <= ~pb_q;
              default:         pb_q <= pb_q;
            endcase
          end
        end
      end

      // Pin enables load with the io word, so they never lag its mode
      assign PIN_A_OUT[n] = pa_q;
      assign PIN_B_OUT[n] = pb_q;
      assign PIN_A_OE[n]  = oe_q[0];
      assign PIN_B_OE[n]  = oe_q[1];
      assign IRQ_REQ[n]   = irq_q;

      // Channel read word for the held read address
      always @* begin
        case (rd_addr_q[`PTU_WORD_R])
          `PTU_CTL_OFS: rd_w = {25'h0000000, ctl_q};
          `PTU_IO_OFS:  rd_w = {24'h000000, io_q};
          `PTU_IEN_OFS: rd_w = {27'h0000000, ien_q};
          `PTU_FLG_OFS: rd_w = {27'h0000000, flg_q};
          `PTU_CNT_OFS: rd_w = {16'h0000, cnt_q};
          `PTU_GRA_OFS: rd_w = {16'h0000, gra_q};
          `PTU_GRB_OFS: rd_w = {16'h0000, grb_q};
          `PTU_GRC_OFS: rd_w = HAS_BUF ? {16'h0000, grc_q} : 32'h0000_0000;
          `PTU_GRD_OFS: rd_w = HAS_BUF ? {16'h0000, grd_q} : 32'h0000_0000;
          default:      rd_w = 32'h0000_0000;
        endcase
      end
      assign ch_rd[32*n +: 32] = rd_w;
    end
  endgenerate

  assign HRDATA    = hrdata_q;
  assign HREADYOUT = hready_q;
  assign HRESP     = hresp_q;

endmodule // ptu_timer

`default_nettype wire

//--- verilog/ptu_timer_map.vh
`ifndef PTU_TIMER_MAP_VH
`define PTU_TIMER_MAP_VH

// Global register word indices (channel field zero)
`define PTU_RUN_OFS      4'h0
`define PTU_SYNC_OFS     4'h1
// Channel n lives at byte base (n+1)*64; word index inside a channel
`define PTU_CH_NUM_R     8:6
`define PTU_WORD_R       5:2
`define PTU_CTL_OFS      4'h0
`define PTU_IO_OFS       4'h1
`define PTU_IEN_OFS      4'h2
`define PTU_FLG_OFS      4'h3
`define PTU_CNT_OFS      4'h4
`define PTU_GRA_OFS      4'h5
`define PTU_GRB_OFS      4'h6
`define PTU_GRC_OFS      4'h7
`define PTU_GRD_OFS      4'h8

// Control register fields
`define PTU_CTL_PSC_R    1:0
`define PTU_CTL_CLR_R    4:2
`define PTU_CTL_BUFA     5
`define PTU_CTL_BUFB     6
`define PTU_CTL_RST      7'h00
// Count clock prescaler selections
`define PTU_PSC_DIV1     2'h0
`define PTU_PSC_DIV4     2'h1
`define PTU_PSC_DIV16    2'h2
`define PTU_PSC_DIV64    2'h3
`define PTU_PRE_MAX4     2'h3
`define PTU_PRE_MAX16    4'hf
`define PTU_PRE_MAX64    6'h3f
// Clear source selections
`define PTU_CLR_NONE     3'h0
`define PTU_CLR_A        3'h1
`define PTU_CLR_B        3'h2
`define PTU_CLR_SYNC     3'h3

// IO register: A in bits 3:0, B in bits 7:4
`define PTU_IO_A_R       3:0
`define PTU_IO_B_R       7:4
`define PTU_IO_RST       8'h00
`define PTU_IO_CAP       3
`define PTU_IO_INT       2
`define PTU_IO_MODE_R    1:0
`define PTU_OUT_NONE     2'h0
`define PTU_OUT_LOW      2'h1
`define PTU_OUT_HIGH     2'h2
`define PTU_OUT_TOGGLE   2'h3
`define PTU_EDGE_RISE    2'h0
`define PTU_EDGE_FALL    2'h1

// Flag and interrupt enable layout
`define PTU_FLG_A        0
`define PTU_FLG_B        1
`define PTU_FLG_OVF      4
`define PTU_FLG_W        5
`define PTU_FLG_RST      5'h00
`define PTU_CNT_MAX      16'hffff
`define PTU_CNT_ZERO     16'h0000

// AHB-Lite codes
`define PTU_HTRANS_NSEQ  1

`endif

//--- testbench/ptu_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module ptu_timer_props #(
  parameter NCH = 6
) (
  // Clock and reset
  input wire logic           CORE_CLK,
  input wire logic           SYS_RST,
  // Bus
  input wire logic           HSEL,
  input wire logic [1:0]     HTRANS,
  input wire logic           HWRITE,
  input wire logic           HREADY,
  input wire logic [31:0]    HRDATA,
  input wire logic           HREADYOUT,
  input wire logic           HRESP,
  // Pins and requests
  input wire logic [NCH-1:0] PIN_A_OUT,
  input wire logic [NCH-1:0] PIN_A_OE,
  input wire logic [NCH-1:0] PIN_B_OUT,
  input wire logic [NCH-1:0] PIN_B_OE,
  input wire logic [NCH-1:0] IRQ_REQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic wr_q;
  // Marks the data phase of a write, when registers take new values
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) wr_q <= 1'b0;
    else wr_q <= HSEL & HREADY & HTRANS[1] & HWRITE;
  end
  sequence s_rd_take;
    HSEL && HREADY && HTRANS[1] && !HWRITE;
  endsequence
  sequence s_rd_ans;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_read_one_wait: assert property (s_rd_take |=> s_rd_ans)
    else $error("read answer not after exactly one wait");
  a_write_no_wait: assert property (HSEL && HREADY && HTRANS[1] && HWRITE
    |=> HREADYOUT) else $error("write stalled");
  a_resp_okay: assert property (HRESP == 1'b0) else $error("error response");
  a_rdata_hold: assert property (!$stable(HRDATA) |-> $past(!HREADYOUT))
    else $error("read data moved outside a read");
  a_rdata_upper: assert property (HRDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_pin_a_owned: assert property (((PIN_A_OUT ^ $past(PIN_A_OUT))
    & ~$past(PIN_A_OE)) == '0) else $error("A pin moved while not output");
  a_pin_b_owned: assert property (((PIN_B_OUT ^ $past(PIN_B_OUT))
    & ~$past(PIN_B_OE)) == '0) else $error("B pin moved while not output");
  a_oe_by_write: assert property (!$stable({PIN_A_OE, PIN_B_OE})
    |-> $past(wr_q)) else $error("output enable moved without a write");
  a_irq_fall_write: assert property (|($past(IRQ_REQ) & ~IRQ_REQ)
    |-> $past(wr_q, 2)) else $error("request dropped without a write");
  a_reset_quiet: assert property (disable iff (1'b0) SYS_RST
    |-> IRQ_REQ == '0 && PIN_A_OUT == '0 && PIN_A_OE == '0 && HREADYOUT)
    else $error("outputs active in reset");
endmodule // ptu_timer_props
bind ptu_timer ptu_timer_props #(.NCH(NCH)) u_props (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIN_A_OUT(PIN_A_OUT),
  .PIN_A_OE(PIN_A_OE), .PIN_B_OUT(PIN_B_OUT), .PIN_B_OE(PIN_B_OE),
  .IRQ_REQ(IRQ_REQ));
`default_nettype wire

//--- testbench/ptu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptu_pin_model (
  // Levels of the external sources
  input  wire logic [5:0] src_a,
  input  wire logic [5:0] src_b,
  // Timer pin drivers
  input  wire logic [5:0] out_a,
  input  wire logic [5:0] oe_a,
  input  wire logic [5:0] out_b,
  input  wire logic [5:0] oe_b,
  // Levels seen at the pins
  output var  logic [5:0] in_a,
  output var  logic [5:0] in_b
);
  // Timer wins while enabled; the source only drives released pins
  always_comb begin
    in_a = (oe_a & out_a) | (~oe_a & src_a);
    in_b = (oe_b & out_b) | (~oe_b & src_b);
  end
endmodule // ptu_pin_model
`default_nettype wire

//--- testbench/test_ptu_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_ptu_timer;
  logic        core_clk;
  logic        sys_rst;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  logic [5:0]  src_a;
  logic [5:0]  src_b;
  wire  [5:0]  in_a, in_b, out_a, oe_a, out_b, oe_b, irq;
  logic        rdy_s;
  logic [31:0] rdata_s;
  logic [31:0] c;
  int          num_errors;
  int          checks_done;
  int          n;
  ptu_timer dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PIN_A_IN(in_a), .PIN_B_IN(in_b),
    .PIN_A_OUT(out_a), .PIN_A_OE(oe_a), .PIN_B_OUT(out_b), .PIN_B_OE(oe_b),
    .IRQ_REQ(irq));
  ptu_pin_model u_pins (.src_a(src_a), .src_b(src_b), .out_a(out_a),
    .oe_a(oe_a), .out_b(out_b), .oe_b(oe_b), .in_a(in_a), .in_b(in_b));
  ////////////////////////////////////////////////////////////////////////
  // Clock; bus answers copied mid-cycle so edge reads never race
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    rdy_s <= hreadyout;
    rdata_s <= hrdata;
  end
  function automatic logic [11:0] ra(input int ch, input int off);
    ra = 12'(ch * 64 + 64 + off);
  endfunction
  task automatic stop_test;
    begin
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks_done++;
      if (got !== exp) begin
        num_errors++;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task automatic wait_rdy;
    begin
      @(posedge core_clk);
      while (rdy_s !== 1'b1) @(posedge core_clk);
    end
  endtask
  // Single AHB transfers; each ends mid-cycle so checks see settled pins
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    begin
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      q = rdata_s;
      @(negedge core_clk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    begin
      xfer(1'b1, a, d, q);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    begin
      xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
    end
  endtask
  // Waits for a toggle of pin A, then counts cycles to the next one
  task automatic period_a(input int ch, input int exp);
    int k;
    logic l;
    begin
      for (int i = 0; i < 2; i++) begin
        k = 0;
        l = out_a[ch];
        while (out_a[ch] === l && k < 300) begin
          @(negedge core_clk);
          k++;
        end
      end
      chk(32'(k), 32'(exp));
    end
  endtask
  task automatic edge_a3(input logic lvl);
    begin
      @(posedge core_clk);
      src_a[3] <= lvl;
      repeat (3) @(negedge core_clk);
    end
  endtask
  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src_a = 6'h00;
    src_b = 6'h00;
    num_errors = 0;
    checks_done = 0;
    // Rising reset edge before the first clock so every flop starts known
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(12'h000, 32'h0);
    for (n = 0; n < 6; n++) begin
      rdc(ra(n, 'h00), 32'h0);
      rdc(ra(n, 'h14), 32'hffff);
    end
    wr(12'h008, 32'h5);
    rdc(12'h008, 32'h0);
    // Periodic toggle on channel 0, period A+1
    wr(ra(0, 'h14), 32'h2);
    wr(ra(0, 'h00), 32'h04);
    wr(ra(0, 'h04), 32'h3);
    wr(ra(0, 'h08), 32'h1);
    wr(12'h000, 32'h1);
    period_a(0, 3);
    rdc(ra(0, 'h0c), 32'h1);
    chk(32'(irq[0]), 32'h1);
    // Halt keeps count and pin
    wr(12'h000, 32'h0);
    n = int'(out_a[0]);
    xfer(1'b0, ra(0, 'h10), 32'h0, c);
    repeat (10) @(negedge core_clk);
    rdc(ra(0, 'h10), c);
    chk(32'(out_a[0]), 32'(n));
    // Buffered compare: C moves into A on each match
    wr(ra(0, 'h00), 32'h24);
    wr(ra(0, 'h1c), 32'h7);
    wr(ra(0, 'h10), 32'h0);
    wr(12'h000, 32'h1);
    period_a(0, 8);
    rdc(ra(0, 'h14), 32'h7);
    wr(12'h000, 32'h0);
    // Overflow on channel 1; ffff also matches A and B
    wr(ra(1, 'h10), 32'hfffd);
    wr(ra(1, 'h08), 32'h10);
    wr(12'h000, 32'h2);
    repeat (4) @(negedge core_clk);
    rdc(ra(1, 'h0c), 32'h13);
    chk(32'(irq[1]), 32'h1);
    xfer(1'b0, ra(1, 'h10), 32'h0, c);
    chk(32'(c < 32'h20 && c > 32'h0), 32'h1);
    wr(12'h000, 32'h0);
    wr(ra(1, 'h0c), 32'h13);
    rdc(ra(1, 'h0c), 32'h0);
    chk(32'(irq[1]), 32'h0);
    // Fixed output levels on channel 2, repeated level stays put
    wr(ra(2, 'h14), 32'h5);
    wr(ra(2, 'h00), 32'h04);
    wr(12'h000, 32'h4);
    for (n = 0; n < 4; n++) begin
      wr(ra(2, 'h04), (n < 2) ? 32'h2 : 32'h1);
      repeat (20) @(negedge core_clk);
      chk(32'(out_a[2]), (n < 2) ? 32'h1 : 32'h0);
      chk(32'(oe_a[2]), 32'h1);
    end
    wr(12'h000, 32'h0);
    // Capture edges on stopped channel 3: rise, fall, both
    for (n = 0; n < 3; n++) begin
      wr(ra(3, 'h04), 32'(8 + n));
      wr(ra(3, 'h10), 32'(256 + n));
      wr(ra(3, 'h14), 32'hbeef);
      edge_a3(1'b1);
      rdc(ra(3, 'h14), (n != 1) ? 32'(256 + n) : 32'hbeef);
      wr(ra(3, 'h14), 32'hbeef);
      edge_a3(1'b0);
      rdc(ra(3, 'h14), (n != 0) ? 32'(256 + n) : 32'hbeef);
    end
    // Buffered capture moves the old A into C
    wr(ra(3, 'h00), 32'h20);
    wr(ra(3, 'h04), 32'h8);
    wr(ra(3, 'h14), 32'h1111);
    wr(ra(3, 'h10), 32'h0222);
    edge_a3(1'b1);
    rdc(ra(3, 'h14), 32'h0222);
    rdc(ra(3, 'h1c), 32'h1111);
    // Channel 3 captures on channel 4 ticks, but never on undivided ones
    wr(ra(3, 'h04), 32'hc);
    wr(ra(3, 'h14), 32'hbeef);
    wr(ra(3, 'h10), 32'h0333);
    wr(12'h000, 32'h10);
    repeat (8) @(negedge core_clk);
    rdc(ra(3, 'h14), 32'hbeef);
    wr(ra(4, 'h00), 32'h1);
    repeat (8) @(negedge core_clk);
    rdc(ra(3, 'h14), 32'h0333);
    wr(12'h000, 32'h0);
    // Sync preset and sync clear across channels 0 and 5
    wr(12'h004, 32'h21);
    wr(ra(0, 'h10), 32'h0abc);
    rdc(ra(5, 'h10), 32'h0abc);
    wr(ra(0, 'h10), 32'h0);
    wr(ra(0, 'h00), 32'h04);
    wr(ra(5, 'h00), 32'h0c);
    wr(12'h000, 32'h21);
    repeat (10) @(negedge core_clk);
    xfer(1'b0, ra(5, 'h10), 32'h0, c);
    chk(32'(c < 32'h8), 32'h1);
    stop_test;
  end
endmodule // test_ptu_timer
`default_nettype wire
